// ---- core/tpmcc_defs.svh ----
// constants of the test mode pin mux and chip control block
`ifndef TPMCC_DEFS_SVH
`define TPMCC_DEFS_SVH

// register port geometry
`define TPMCC_AW             4
`define TPMCC_DW             8

// register offsets (word index on the plain register port)
`define TPMCC_REG_CTRL       4'h0
`define TPMCC_REG_STAT       4'h1
`define TPMCC_REG_ID         4'h2

// control register fields
`define TPMCC_CTRL_OVR_EN    0
`define TPMCC_CTRL_OVR_ONE   1
`define TPMCC_CTRL_RST       2'h0

// status register fields
`define TPMCC_STAT_STRAP_LSB 0
`define TPMCC_STAT_TEST      4
`define TPMCC_STAT_TWO_LANE  5
`define TPMCC_STAT_PWR_LSB   6

// identity read back on the register port and through the test port; value is arbitrary
`define TPMCC_ID_REG         8'h5A
`define TPMCC_IDCODE         32'h0A5C_3001

// test access port instructions
`define TPMCC_IR_LEN         4
`define TPMCC_IR_IDCODE      4'h1
`define TPMCC_IR_BYPASS      4'hF
`define TPMCC_DR_LEN         32

`endif

// ---- core/tpmcc_pkg.sv ----
// types of the test mode pin mux and chip control block
package tpmcc_pkg;

   // power sequencing: down -> hold -> run along a Gray path
   typedef enum logic [1:0]
   {
      PWR_DOWN = 2'b00,
      PWR_HOLD = 2'b01,
      PWR_RUN  = 2'b11
   } tpmcc_pwr_t;

   // test access port controller
   typedef enum logic [3:0]
   {
      TAP_RESET  = 4'h0,
      TAP_IDLE   = 4'h1,
      TAP_SEL_DR = 4'h3,
      TAP_CAP_DR = 4'h2,
      TAP_SH_DR  = 4'h6,
      TAP_EX1_DR = 4'h7,
      TAP_PA_DR  = 4'h5,
      TAP_EX2_DR = 4'h4,
      TAP_UP_DR  = 4'hC,
      TAP_SEL_IR = 4'hD,
      TAP_CAP_IR = 4'hF,
      TAP_SH_IR  = 4'hE,
      TAP_EX1_IR = 4'hA,
      TAP_PA_IR  = 4'hB,
      TAP_EX2_IR = 4'h9,
      TAP_UP_IR  = 4'h8
   } tpmcc_tap_t;

   // configuration straps as captured when the core leaves reset
   typedef struct packed
   {
      logic four;
      logic three;
      logic two;
      logic one;
   } tpmcc_straps_t;

   // chip status presented to the rest of the bridge
   typedef struct packed
   {
      logic          core_run;
      logic          deep_down;
      logic          test_active;
      logic          two_lane;
      tpmcc_straps_t straps;
   } tpmcc_status_t;

   // whole state of the chip control block
   typedef struct packed
   {
      tpmcc_pwr_t    pwr;
      tpmcc_straps_t straps;
      logic [1:0]    ctrl;
      logic [7:0]    rd_data;
      logic          tck_q;
      tpmcc_tap_t    tap;
      logic [3:0]    ir_sh;
      logic [3:0]    ir;
      logic [31:0]   dr_sh;
      logic          tdo;
   } tpmcc_state_t;

endpackage

// ---- core/tpmcc_chip_ctrl.sv ----
// chip control: power-down, chip reset, strap capture and test port pin mux
`timescale 1ns/1ps
`include "tpmcc_defs.svh"

module tpmcc_chip_ctrl
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  power_down_in_n,
   input  wire logic                  test_select_in,
   input  wire logic                  strap_pin_one,
   input  wire logic                  strap_pin_two,
   input  wire logic                  strap_pin_three,
   input  wire logic                  strap_pin_four_in,
   output logic                       strap_pin_four_out,
   output logic                       strap_pin_four_oe,
   input  wire logic [`TPMCC_AW-1:0]  reg_addr,
   input  wire logic [`TPMCC_DW-1:0]  reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [`TPMCC_DW-1:0]       reg_rdata,
   output tpmcc_pkg::tpmcc_status_t   status
);
   import tpmcc_pkg::*;

   tpmcc_state_t q_ff;
   tpmcc_state_t nxt_q;
   logic         test_mode;
   logic         tck_rise;
   logic         tck_fall;
   logic         two_lane;

   // next state of the test access port controller
   function automatic tpmcc_tap_t tap_next(input tpmcc_tap_t st, input logic tms);
      tpmcc_tap_t n;
      n = st;
      unique case (st)
         TAP_RESET:  n = tms ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   n = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  n = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: n = tms ? TAP_UP_DR  : TAP_PA_DR;
         TAP_PA_DR:  n = tms ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: n = tms ? TAP_UP_DR  : TAP_SH_DR;
         TAP_UP_DR:  n = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: n = tms ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  n = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: n = tms ? TAP_UP_IR  : TAP_PA_IR;
         TAP_PA_IR:  n = tms ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: n = tms ? TAP_UP_IR  : TAP_SH_IR;
         TAP_UP_IR:  n = tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
      return n;
   endfunction

   // default contents of every flip-flop in the block
   function automatic tpmcc_state_t state_default(input tpmcc_pwr_t pwr);
      tpmcc_state_t d;
      d         = '0;
      d.pwr     = pwr;
      d.ctrl    = `TPMCC_CTRL_RST;
      d.tap     = TAP_RESET;
      d.ir      = `TPMCC_IR_IDCODE;
      d.ir_sh   = `TPMCC_IR_IDCODE;
      return d;
   endfunction

   // the test port only exists while the core runs and test-select is high
   assign test_mode = test_select_in && (q_ff.pwr == PWR_RUN);

   // pins are synchronous to clk, so the test clock is used through edge enables
   assign tck_rise  = test_mode && strap_pin_one && !q_ff.tck_q;
   assign tck_fall  = test_mode && !strap_pin_one && q_ff.tck_q;

   // software may override the lane count taken from the strap
   assign two_lane  = q_ff.ctrl[`TPMCC_CTRL_OVR_EN] ?
                      !q_ff.ctrl[`TPMCC_CTRL_OVR_ONE] : !q_ff.straps.three;

   always_comb
   begin
      nxt_q         = q_ff;
      nxt_q.rd_data = '0;
      nxt_q.tck_q   = test_mode ? strap_pin_one : 1'b0;

      unique case (q_ff.pwr)
         PWR_DOWN:
         begin
            // deep power-down: nothing but the wake path is alive
            nxt_q = state_default(power_down_in_n ? PWR_HOLD : PWR_DOWN);
         end
         PWR_HOLD:
         begin
            // straps are caught on the way out of reset, in strap mode only
            nxt_q = state_default(power_down_in_n ? PWR_RUN : PWR_DOWN);
            if (power_down_in_n && !test_select_in)
            begin
               nxt_q.straps.one   = strap_pin_one;
               nxt_q.straps.two   = strap_pin_two;
               nxt_q.straps.three = strap_pin_three;
               nxt_q.straps.four  = strap_pin_four_in;
            end
         end
         PWR_RUN:
         begin
            if (!power_down_in_n)
            begin
               nxt_q = state_default(PWR_DOWN);
            end
            else
            begin
               // register port
               if (reg_wr && reg_addr == `TPMCC_REG_CTRL)
               begin
                  nxt_q.ctrl = reg_wdata[1:0];
               end
               if (reg_rd)
               begin
                  unique case (reg_addr)
                     `TPMCC_REG_CTRL: nxt_q.rd_data = {6'h00, q_ff.ctrl};
                     `TPMCC_REG_STAT: nxt_q.rd_data = {q_ff.pwr, two_lane, test_mode,
                                                       q_ff.straps};
                     `TPMCC_REG_ID:   nxt_q.rd_data = `TPMCC_ID_REG;
                     default:         nxt_q.rd_data = 8'h00;
                  endcase
               end

               // test access port; leaving test mode parks it in reset
               if (!test_mode)
               begin
                  nxt_q.tap   = TAP_RESET;
                  nxt_q.ir    = `TPMCC_IR_IDCODE;
                  nxt_q.ir_sh = `TPMCC_IR_IDCODE;
                  nxt_q.dr_sh = '0;
                  nxt_q.tdo   = 1'b0;
               end
               else if (tck_rise)
               begin
                  unique case (q_ff.tap)
                     TAP_RESET:
                     begin
                        nxt_q.ir = `TPMCC_IR_IDCODE;
                     end
                     TAP_CAP_DR:
                     begin
                        nxt_q.dr_sh = (q_ff.ir == `TPMCC_IR_IDCODE) ? `TPMCC_IDCODE : 32'h0;
                     end
                     TAP_SH_DR:
                     begin
                        // bypass is one bit long, the identity register 32
                        if (q_ff.ir == `TPMCC_IR_IDCODE)
                        begin
                           nxt_q.dr_sh = {strap_pin_three, q_ff.dr_sh[31:1]};
                        end
                        else
                        begin
                           nxt_q.dr_sh = {31'h0, strap_pin_three};
                        end
                     end
                     TAP_CAP_IR:
                     begin
                        nxt_q.ir_sh = 4'h1;
                     end
                     TAP_SH_IR:
                     begin
                        nxt_q.ir_sh = {strap_pin_three, q_ff.ir_sh[3:1]};
                     end
                     TAP_UP_IR:
                     begin
                        // unknown codes fall back to bypass
                        nxt_q.ir = (q_ff.ir_sh == `TPMCC_IR_IDCODE) ?
                                   `TPMCC_IR_IDCODE : `TPMCC_IR_BYPASS;
                     end
                     default:
                     begin
                        nxt_q.ir = q_ff.ir;
                     end
                  endcase
                  nxt_q.tap = tap_next(q_ff.tap, strap_pin_two);
               end
               else if (tck_fall)
               begin
                  // output data changes on the falling test clock edge
                  if (q_ff.tap == TAP_SH_DR)
                  begin
                     nxt_q.tdo = q_ff.dr_sh[0];
                  end
                  else if (q_ff.tap == TAP_SH_IR)
                  begin
                     nxt_q.tdo = q_ff.ir_sh[0];
                  end
               end
            end
         end
      endcase
   end

   // reset holds the block in the hold state; release replays the default load
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q_ff <= state_default(PWR_HOLD);
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   // pin four is driven only while the test port owns it
   assign strap_pin_four_out = test_mode ? q_ff.tdo : 1'b0;
   assign strap_pin_four_oe  = test_mode;

   assign reg_rdata          = q_ff.rd_data;

   assign status.core_run    = (q_ff.pwr == PWR_RUN);
   assign status.deep_down   = (q_ff.pwr == PWR_DOWN);
   assign status.test_active = test_mode;
   assign status.two_lane    = two_lane;
   assign status.straps      = q_ff.straps;

endmodule

// ---- testbench/tpmcc_chip_ctrl_assertions.sv ----
// concurrent checks on the chip control ports
`timescale 1ns/1ps
module tpmcc_chip_ctrl_chk
(
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     power_down_in_n,
   input wire logic                     test_select_in,
   input wire logic                     strap_pin_one,
   input wire logic                     strap_pin_two,
   input wire logic                     strap_pin_three,
   input wire logic                     strap_pin_four_in,
   input wire logic                     strap_pin_four_out,
   input wire logic                     strap_pin_four_oe,
   input wire tpmcc_pkg::tpmcc_status_t status
);
   import tpmcc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_pd_stop: assert property (!power_down_in_n |=> status.deep_down && !status.core_run)
      else $error("power-down did not stop the core");
   chk_rst_hold: assert property (disable iff (1'b0) !rst_n |=> !status.core_run && !strap_pin_four_oe)
      else $error("core ran while held in reset");
   chk_run_entry: assert property (!status.core_run && !status.deep_down && power_down_in_n |=> status.core_run)
      else $error("core did not start after release");
   chk_wake_path: assert property (status.deep_down && power_down_in_n ##1 power_down_in_n |-> !status.deep_down ##1 status.core_run)
      else $error("wake from power-down out of order");
   chk_oe_mode: assert property (strap_pin_four_oe == (test_select_in && status.core_run))
      else $error("pin four driver enable wrong");
   chk_tdo_quiet: assert property (!test_select_in |=> !strap_pin_four_out)
      else $error("pin four output active in strap mode");
   chk_strap_take: assert property (!status.core_run && !status.deep_down && power_down_in_n && !test_select_in
      |=> status.straps == $past({strap_pin_four_in, strap_pin_three, strap_pin_two, strap_pin_one}))
      else $error("straps not captured");
   chk_lane_pick: assert property ($rose(status.core_run) |-> status.two_lane == !status.straps.three)
      else $error("lane count does not follow strap three");
   chk_tdo_fall: assert property (test_select_in && $past(test_select_in) && status.core_run
      && $changed(strap_pin_four_out) |-> $past(strap_pin_one, 2) && !$past(strap_pin_one))
      else $error("test data out moved off a test clock fall");
   cover property (status.deep_down);
   cover property (status.test_active);
   cover property ($rose(status.core_run) && status.straps != 4'h0);
endmodule

// ---- testbench/tpmcc_tester.sv ----
// board straps and bit-banging test port driver
`timescale 1ns/1ps
module tpmcc_tester
(
   input wire logic        clk,
   input wire logic [3:0]  strap_val,
   input wire logic        test_on,
   input wire logic        pin_four_out,
   input wire logic        pin_four_oe,
   output logic            pin_one,
   output logic            pin_two,
   output logic            pin_three,
   output logic            pin_four_in
);
   logic tck_r = 1'b0;
   logic tms_r = 1'b0;
   logic tdi_r = 1'b0;
   assign pin_one = test_on ? tck_r : strap_val[0];
   assign pin_two = test_on ? tms_r : strap_val[1];
   assign pin_three = test_on ? tdi_r : strap_val[2];
   // undriven pin four has no pull, so show a changing level rather than a stale one
   assign pin_four_in = pin_four_oe ? pin_four_out : (test_on ? ~pin_four_out : strap_val[3]);
   // tck high and low each span at least two clk cycles
   task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo);
      @(posedge clk);
      tms_r <= tms;
      tdi_r <= tdi;
      tck_r <= 1'b1;
      repeat (2) @(posedge clk);
      tck_r <= 1'b0;
      repeat (2) @(posedge clk);
      tdo = pin_four_out;
   endtask
endmodule

// ---- testbench/tpmcc_chip_ctrl_test.sv ----
// self-checking bench for the chip control block
`timescale 1ns/1ps
`include "tpmcc_defs.svh"
module tpmcc_chip_ctrl_test;
   import tpmcc_pkg::*;
   logic          clk = 0, rst_n = 0, pd_n = 1, tsel = 0, wr = 0, rd = 0;
   logic [3:0]    sv = 0, addr = 0;
   logic [7:0]    wd = 0, rdat, d, pat = 8'h96;
   logic [31:0]   idc = `TPMCC_IDCODE;
   logic          p1, p2, p3, p4, t_out, t_oe, b;
   tpmcc_status_t st;
   int            bad_count = 0, num_checks = 0, cyc = 0, i;
   always #25 clk = ~clk;
   tpmcc_tester tester (.clk(clk), .strap_val(sv), .test_on(tsel), .pin_four_out(t_out),
      .pin_four_oe(t_oe), .pin_one(p1), .pin_two(p2), .pin_three(p3), .pin_four_in(p4));
   tpmcc_chip_ctrl uut (.clk(clk), .rst_n(rst_n), .power_down_in_n(pd_n), .test_select_in(tsel),
      .strap_pin_one(p1), .strap_pin_two(p2), .strap_pin_three(p3), .strap_pin_four_in(p4),
      .strap_pin_four_out(t_out), .strap_pin_four_oe(t_oe), .reg_addr(addr), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .status(st));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdat;
   endtask
   task automatic boot(input logic ts, input logic [3:0] s);
      @(posedge clk);
      rst_n <= 1'b0;
      tsel <= ts;
      sv <= s;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   initial
   begin
      for (i = 0; i < 16; i++)
      begin
         boot(1'b0, i[3:0]);
         rd_reg(`TPMCC_REG_STAT, d);
         chk(d, {2'b11, ~i[2], 1'b0, i[3:0]});
         chk({7'h00, t_oe}, 8'h00);
      end
      $display("strap capture done");
      boot(1'b0, 4'h0);
      wr_reg(`TPMCC_REG_CTRL, 8'h03);
      wr_reg(`TPMCC_REG_ID, 8'h00);
      rd_reg(`TPMCC_REG_STAT, d);
      chk(d, 8'hC0);
      rd_reg(`TPMCC_REG_ID, d);
      chk(d, `TPMCC_ID_REG);
      rd_reg(4'hF, d);
      chk(d, 8'h00);
      // mid-run reset is raised on a rising edge like every other input
      @(posedge clk);
      rst_n <= 1'b0;
      rd_reg(`TPMCC_REG_ID, d);
      chk(d, 8'h00);
      boot(1'b0, 4'h0);
      rd_reg(`TPMCC_REG_STAT, d);
      chk(d, 8'hE0);
      $display("register defaults done");
      @(posedge clk);
      pd_n <= 1'b0;
      rd_reg(`TPMCC_REG_ID, d);
      chk(d, 8'h00);
      chk({6'h00, st.deep_down, st.core_run}, 8'h02);
      @(posedge clk);
      sv <= 4'h4;
      pd_n <= 1'b1;
      rd_reg(`TPMCC_REG_STAT, d);
      rd_reg(`TPMCC_REG_STAT, d);
      chk(d, 8'hC4);
      $display("power-down done");
      boot(1'b1, 4'h0);
      chk({7'h00, t_oe}, 8'h01);
      for (i = 0; i < 40; i++)
      begin
         tester.tck_cycle(i == 1, pat[i % 8], b);
         if (i >= 3)
            chk({7'h00, b}, {7'h00, i < 35 ? idc[i - 3] : pat[(i - 31) % 8]});
      end
      tsel <= 1'b0;
      repeat (2) @(negedge clk);
      chk({6'h00, t_oe, t_out}, 8'h00);
      $display("test port done");
      print_verdict();
   end
endmodule
bind tpmcc_chip_ctrl tpmcc_chip_ctrl_chk chk_i (.clk(clk), .rst_n(rst_n),
   .power_down_in_n(power_down_in_n), .test_select_in(test_select_in),
   .strap_pin_one(strap_pin_one), .strap_pin_two(strap_pin_two), .strap_pin_three(strap_pin_three),
   .strap_pin_four_in(strap_pin_four_in), .strap_pin_four_out(strap_pin_four_out),
   .strap_pin_four_oe(strap_pin_four_oe), .status(status));
